//--- verilog/standby_mode_controller.sv
// Standby and idle operating-mode controller
//
// Operation
// - Edge release: rising standby pin; entry always
// - Level release: pin high or key low
// - Restart oscillators per target clock mode
// - Warm-up keeps all internal operation halted
// - Six warm-up lengths from 3-bit select
// - Warm-up counts the restarting oscillator ticks
// - After warm-up resume at next instruction
// - Clear prescaler and divider before restart
// - Reset pin low aborts standby immediately
// - CPU-halt idle stops CPU and watchdog
// - Idle holds state and program counter
// - Leaving CPU-halt idle clears its bit
// - Reset releases idle; restart fast single
// - Master off: wake, resume, no service
// - Master on: wake and service interrupt
// - Watchdog interrupt before entry cancels entry
// - Gated idle clocks only time-base timer
// - Leaving gated idle clears its bit
// - Time-base enabled: set its latch on entry
// - Gated idle ends on source falling edge
// - Gated idle release: service if master, time-base irq and time-base enabled, else resume
`timescale 1ns/1ps
module standby_mode_controller #(
   parameter int KEYS       = 4,
   parameter int WARM_SHIFT = 0
) (
   input  wire logic                    i_mclk,
   input  wire logic                    i_rst_n,
   input  wire logic                    i_ext_reset_n,
   input  wire logic                    i_fc_tick,
   input  wire logic                    i_fs_tick,
   input  wire standby_pkg::standby_cfg_s i_cfg,
   input  wire standby_pkg::irq_s       i_irq,
   input  wire logic                    i_stop_req,
   input  wire logic                    i_cpu_halt_set,
   input  wire logic                    i_clock_gate_set,
   input  wire logic                    i_mode_write,
   input  wire standby_pkg::op_mode_e   i_mode_next,
   input  wire logic                    i_standby_pin,
   input  wire logic [KEYS-1:0]         i_key_wakeup_n,
   input  wire logic [KEYS-1:0]         i_key_enable,
   input  wire logic                    i_time_base_src,
   output standby_pkg::op_mode_e        o_mode,
   output logic                         o_fast_osc_on,
   output logic                         o_slow_osc_on,
   output logic                         o_cpu_run,
   output logic                         o_watchdog_run,
   output logic                         o_periph_clk_en,
   output logic                         o_tbt_clk_en,
   output logic                         o_divider_clear,
   output logic                         o_standby_active,
   output logic                         o_cpu_halt_idle,
   output logic                         o_clock_gate_halt,
   output logic                         o_timebase_latch_set,
   output logic                         o_service_irq,
   output logic                         o_resume,
   output logic                         o_pc_hold,
   output logic                         o_core_reset,
   output logic                         o_warmup_done
);

   if (KEYS < 1 || WARM_SHIFT < 0 || WARM_SHIFT > 10) begin : g_bad_param
      $error("standby_mode_controller: unsupported parameter value");
   end

   standby_pkg::pm_state_e          state;
   standby_pkg::pm_state_e          next_state;
   logic                            rst_pin;
   logic                            pin_rise;
   logic                            tb_fall;
   logic                            key_wake;
   logic                            level_wake;
   logic                            release_stop;
   logic                            any_req;
   logic                            tb_service;
   logic                            warm_start;
   logic                            warm_tick;
   logic                            warm_done;
   logic [standby_pkg::WARM_W-1:0]  warm_table;
   logic [standby_pkg::WARM_W-1:0]  warm_terminal;

   assign rst_pin  = ~i_ext_reset_n;
   assign key_wake = |(i_key_enable & ~i_key_wakeup_n);
   assign level_wake = i_standby_pin | key_wake;
   assign release_stop = i_cfg.release_level_select ? level_wake : pin_rise;
   assign any_req  = i_stop_req | i_cpu_halt_set | i_clock_gate_set;
   assign tb_service = i_irq.master_irq_enable & i_irq.timebase_irq_enable
                     & i_irq.time_base_enable;

   signal_edge_detect u_pin_edge (
      .i_mclk  (i_mclk),
      .i_rst_n (i_rst_n),
      .i_sig   (i_standby_pin),
      .o_rise  (pin_rise),
      .o_fall  ()
   );

   signal_edge_detect u_tb_edge (
      .i_mclk  (i_mclk),
      .i_rst_n (i_rst_n),
      .i_sig   (i_time_base_src),
      .o_rise  (),
      .o_fall  (tb_fall)
   );

   // Warm-up length and tick source
   assign warm_table = standby_pkg::warm_ticks(i_cfg.warmup_select,
                          o_mode == standby_pkg::slow_clock_mode);
   assign warm_terminal = ((warm_table >> WARM_SHIFT) == '0) ? standby_pkg::WARM_W'(1)
                        : (warm_table >> WARM_SHIFT);
   assign warm_tick = (o_mode == standby_pkg::slow_clock_mode) ? i_fs_tick
                                                               : i_fc_tick;
   assign warm_start = (state != standby_pkg::st_warmup)
                     && (next_state == standby_pkg::st_warmup);

   warmup_counter #(
      .CW (standby_pkg::WARM_W)
   ) u_warmup (
      .i_mclk     (i_mclk),
      .i_rst_n    (i_rst_n),
      .i_start    (warm_start),
      .i_abort    (rst_pin),
      .i_tick     (warm_tick),
      .i_terminal (warm_terminal),
      .o_done     (warm_done)
   );

   // Mode sequencing
   always_comb begin
      next_state = state;
      if (rst_pin) begin
         next_state = standby_pkg::st_run;
      end else begin
         case (state)
            standby_pkg::st_run: begin
               if (any_req && i_irq.watchdog_irq) begin
                  next_state = standby_pkg::st_run;
               end else if (i_stop_req) begin
                  if (i_cfg.release_level_select && level_wake) begin
                     next_state = standby_pkg::st_warmup;
                  end else begin
                     next_state = standby_pkg::st_stopped;
                  end
               end else if (i_cpu_halt_set) begin
                  next_state = standby_pkg::st_idle_cpu;
               end else if (i_clock_gate_set) begin
                  next_state = standby_pkg::st_idle_gated;
               end
            end
            standby_pkg::st_stopped: begin
               if (release_stop) begin
                  next_state = standby_pkg::st_warmup;
               end
            end
            standby_pkg::st_warmup: begin
               if (warm_done) begin
                  next_state = standby_pkg::st_run;
               end
            end
            standby_pkg::st_idle_cpu: begin
               if (i_irq.irq_pending) begin
                  next_state = standby_pkg::st_run;
               end
            end
            standby_pkg::st_idle_gated: begin
               if (tb_fall) begin
                  next_state = standby_pkg::st_run;
               end
            end
            default: begin
               next_state = standby_pkg::st_run;
            end
         endcase
      end
   end

   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         state <= standby_pkg::st_run;
      end else begin
         state <= next_state;
      end
   end

   // Operating mode held across standby and idle
   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_mode <= standby_pkg::fast_single_clock_mode;
      end else if (rst_pin) begin
         o_mode <= standby_pkg::fast_single_clock_mode;
      end else if (i_mode_write && state == standby_pkg::st_run) begin
         o_mode <= i_mode_next;
      end
   end

   // Oscillators, clocks and mode bits
   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_fast_osc_on     <= 1'b1;
         o_slow_osc_on     <= 1'b0;
         o_cpu_run         <= 1'b1;
         o_watchdog_run    <= 1'b1;
         o_periph_clk_en   <= 1'b1;
         o_tbt_clk_en      <= 1'b1;
         o_standby_active  <= 1'b0;
         o_cpu_halt_idle   <= 1'b0;
         o_clock_gate_halt <= 1'b0;
         o_pc_hold         <= 1'b0;
      end else begin
         o_fast_osc_on <= (next_state != standby_pkg::st_stopped)
            && ((rst_pin ? standby_pkg::fast_single_clock_mode : o_mode)
                != standby_pkg::slow_clock_mode);
         o_slow_osc_on <= (next_state != standby_pkg::st_stopped) && !rst_pin
            && (o_mode != standby_pkg::fast_single_clock_mode);
         o_cpu_run       <= next_state == standby_pkg::st_run;
         o_watchdog_run  <= next_state == standby_pkg::st_run;
         o_periph_clk_en <= (next_state == standby_pkg::st_run)
                         || (next_state == standby_pkg::st_idle_cpu);
         o_tbt_clk_en    <= (next_state == standby_pkg::st_run)
                         || (next_state == standby_pkg::st_idle_cpu)
                         || (next_state == standby_pkg::st_idle_gated);
         o_standby_active  <= next_state == standby_pkg::st_stopped;
         o_cpu_halt_idle   <= next_state == standby_pkg::st_idle_cpu;
         o_clock_gate_halt <= next_state == standby_pkg::st_idle_gated;
         o_pc_hold         <= next_state != standby_pkg::st_run;
      end
   end

   // Event pulses
   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_divider_clear      <= 1'b0;
         o_timebase_latch_set <= 1'b0;
         o_service_irq        <= 1'b0;
         o_resume             <= 1'b0;
         o_core_reset         <= 1'b0;
         o_warmup_done        <= 1'b0;
      end else begin
         o_core_reset    <= rst_pin;
         o_divider_clear <= warm_start;
         o_warmup_done   <= warm_done && !rst_pin;
         o_timebase_latch_set <= !rst_pin && state == standby_pkg::st_run
            && i_clock_gate_set && !i_stop_req && !i_cpu_halt_set
            && !i_irq.watchdog_irq && i_irq.time_base_enable;
         o_service_irq <= !rst_pin && (
            (state == standby_pkg::st_run && any_req && i_irq.watchdog_irq)
            || (state == standby_pkg::st_idle_cpu && i_irq.irq_pending
                && i_irq.master_irq_enable)
            || (state == standby_pkg::st_idle_gated && tb_fall && tb_service));
         o_resume <= !rst_pin && (
            (state == standby_pkg::st_warmup && warm_done)
            || (state == standby_pkg::st_idle_cpu && i_irq.irq_pending
                && !i_irq.master_irq_enable)
            || (state == standby_pkg::st_idle_gated && tb_fall && !tb_service));
      end
   end

   // Checks
   default clocking cb @(posedge i_mclk);
   endclocking
   default disable iff (!i_rst_n);

   sequence run_request;
      state == standby_pkg::st_run && !rst_pin && !i_irq.watchdog_irq;
   endsequence

   sequence warm_finish;
      state == standby_pkg::st_warmup && warm_done && !rst_pin
      ##1 state == standby_pkg::st_run && o_resume && o_cpu_run;
   endsequence

   edge_entry_a: assert property (
      run_request ##0 (i_stop_req && !i_cfg.release_level_select)
      |=> state == standby_pkg::st_stopped && o_standby_active && !o_fast_osc_on)
      else $error("edge mode standby not entered");

   level_bypass_a: assert property (
      run_request ##0 (i_stop_req && i_cfg.release_level_select && level_wake)
      |=> state == standby_pkg::st_warmup && !o_standby_active)
      else $error("level wake did not bypass standby");

   osc_restart_a: assert property (
      state == standby_pkg::st_warmup && $stable(o_mode)
      |-> o_fast_osc_on == (o_mode != standby_pkg::slow_clock_mode)
          && o_slow_osc_on == (o_mode != standby_pkg::fast_single_clock_mode))
      else $error("wrong oscillators during warm-up");

   warm_halt_a: assert property (
      state == standby_pkg::st_warmup || state == standby_pkg::st_stopped
      |-> !o_cpu_run && !o_periph_clk_en && !o_tbt_clk_en)
      else $error("activity during standby or warm-up");

   warm_done_a: assert property (
      state == standby_pkg::st_warmup && warm_done && !rst_pin |-> warm_finish)
      else $error("no resume after warm-up");

   divider_clear_a: assert property (
      state == standby_pkg::st_stopped && release_stop && !rst_pin
      |=> o_divider_clear ##1 !o_divider_clear)
      else $error("divider not cleared once on release");

   reset_abort_a: assert property (
      rst_pin |=> state == standby_pkg::st_run && o_core_reset
                  && o_mode == standby_pkg::fast_single_clock_mode)
      else $error("reset pin did not abort");

   cpu_halt_a: assert property (
      state == standby_pkg::st_idle_cpu
      |-> !o_cpu_run && !o_watchdog_run && o_periph_clk_en && o_cpu_halt_idle)
      else $error("cpu halt clocks wrong");

   wake_quiet_a: assert property (
      state == standby_pkg::st_idle_cpu && i_irq.irq_pending
      && !i_irq.master_irq_enable && !rst_pin
      |=> o_resume && !o_service_irq && !o_cpu_halt_idle)
      else $error("quiet wake misbehaved");

   wake_service_a: assert property (
      state == standby_pkg::st_idle_cpu && i_irq.irq_pending
      && i_irq.master_irq_enable && !rst_pin
      |=> o_service_irq && !o_resume && o_cpu_run)
      else $error("service wake misbehaved");

   watchdog_skip_a: assert property (
      state == standby_pkg::st_run && any_req && i_irq.watchdog_irq && !rst_pin
      |=> state == standby_pkg::st_run && o_service_irq)
      else $error("idle entered despite watchdog interrupt");

   gate_clock_a: assert property (
      state == standby_pkg::st_idle_gated
      |-> !o_periph_clk_en && o_tbt_clk_en && o_clock_gate_halt)
      else $error("gated idle clocks wrong");

   tb_latch_a: assert property (
      run_request ##0 (i_clock_gate_set && !i_stop_req && !i_cpu_halt_set)
      |=> o_timebase_latch_set == $past(i_irq.time_base_enable)
          && state == standby_pkg::st_idle_gated)
      else $error("time-base latch not set on entry");

   gate_release_a: assert property (
      state == standby_pkg::st_idle_gated && tb_fall && !rst_pin
      |=> !o_clock_gate_halt && (o_service_irq != o_resume)
          && o_service_irq == $past(tb_service))
      else $error("gated idle release wrong");

endmodule // standby_mode_controller

//--- common/standby_pkg.sv
// Shared constants, types and warm-up table for the standby mode controller
package standby_pkg;

   // Warm-up counter width and oscillator rates
   localparam int     WARM_W   = 18;
   localparam longint FAST_HZ  = 64'd16000000;
   localparam longint SLOW_HZ  = 64'd32768;
   localparam longint US_PER_S = 64'd1000000;

   // Warm-up times in microseconds, return to fast modes
   localparam longint WARM_FAST_000_US = 64'd12288;
   localparam longint WARM_FAST_010_US = 64'd4096;
   localparam longint WARM_FAST_100_US = 64'd3072;
   localparam longint WARM_FAST_110_US = 64'd1024;
   localparam longint WARM_FAST_X01_US = 64'd192;
   localparam longint WARM_FAST_X11_US = 64'd64;

   // Warm-up times in microseconds, return to slow mode
   localparam longint WARM_SLOW_000_US = 64'd750000;
   localparam longint WARM_SLOW_010_US = 64'd250000;
   localparam longint WARM_SLOW_100_US = 64'd5850;
   localparam longint WARM_SLOW_110_US = 64'd1950;
   localparam longint WARM_SLOW_X01_US = 64'd5900;
   localparam longint WARM_SLOW_X11_US = 64'd2000;

   // Warm-up select codes
   localparam logic [2:0] WUP_000 = 3'h0;
   localparam logic [2:0] WUP_010 = 3'h2;
   localparam logic [2:0] WUP_100 = 3'h4;
   localparam logic [2:0] WUP_110 = 3'h6;

   typedef enum logic [1:0] {
      fast_single_clock_mode,
      fast_dual_clock_mode,
      slow_clock_mode
   } op_mode_e;

   typedef enum logic [2:0] {
      st_run,
      st_stopped,
      st_warmup,
      st_idle_cpu,
      st_idle_gated
   } pm_state_e;

   typedef struct packed {
      logic       release_level_select;
      logic [2:0] warmup_select;
   } standby_cfg_s;

   typedef struct packed {
      logic master_irq_enable;
      logic irq_pending;
      logic watchdog_irq;
      logic timebase_irq_enable;
      logic time_base_enable;
   } irq_s;

   // Oscillator ticks for a time, rounded up
   function automatic logic [WARM_W-1:0] to_ticks(input longint us, input longint hz);
      to_ticks = WARM_W'((us * hz + US_PER_S - 64'd1) / US_PER_S);
   endfunction

   // Terminal tick count per warm-up code
   function automatic logic [WARM_W-1:0] warm_ticks(input logic [2:0] code,
                                                     input logic       slow);
      longint us;
      if (code[0]) begin
         us = code[1] ? (slow ? WARM_SLOW_X11_US : WARM_FAST_X11_US)
                      : (slow ? WARM_SLOW_X01_US : WARM_FAST_X01_US);
      end else if (code == WUP_000) begin
         us = slow ? WARM_SLOW_000_US : WARM_FAST_000_US;
      end else if (code == WUP_010) begin
         us = slow ? WARM_SLOW_010_US : WARM_FAST_010_US;
      end else if (code == WUP_100) begin
         us = slow ? WARM_SLOW_100_US : WARM_FAST_100_US;
      end else begin
         us = slow ? WARM_SLOW_110_US : WARM_FAST_110_US;
      end
      warm_ticks = to_ticks(us, slow ? SLOW_HZ : FAST_HZ);
   endfunction

endpackage

//--- verilog/signal_edge_detect.sv
// Rising and falling edge detector for a synchronous input
`timescale 1ns/1ps
module signal_edge_detect (
   input  wire logic i_mclk,
   input  wire logic i_rst_n,
   input  wire logic i_sig,
   output logic      o_rise,
   output logic      o_fall
);

   logic prev;

   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         prev <= 1'b0;
      end else begin
         prev <= i_sig;
      end
   end

   assign o_rise = i_sig & ~prev;
   assign o_fall = ~i_sig & prev;

endmodule // signal_edge_detect

//--- verilog/warmup_counter.sv
// Warm-up counter driven by oscillator tick enables
`timescale 1ns/1ps
module warmup_counter #(
   parameter int CW = 18
) (
   input  wire logic          i_mclk,
   input  wire logic          i_rst_n,
   input  wire logic          i_start,
   input  wire logic          i_abort,
   input  wire logic          i_tick,
   input  wire logic [CW-1:0] i_terminal,
   output logic               o_done
);

   logic [CW-1:0] count;
   logic          active;

   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         count  <= '0;
         active <= 1'b0;
         o_done <= 1'b0;
      end else if (i_abort) begin
         count  <= '0;
         active <= 1'b0;
         o_done <= 1'b0;
      end else if (i_start) begin
         count  <= '0;
         active <= 1'b1;
         o_done <= 1'b0;
      end else begin
         o_done <= 1'b0;
         if (active && i_tick) begin
            if (count == i_terminal - CW'(1)) begin
               active <= 1'b0;
               o_done <= 1'b1;
            end else begin
               count <= count + CW'(1);
            end
         end
      end
   end

endmodule // warmup_counter

//--- verification/far_side_model.sv
// Oscillator tick and time-base source model for the standby bench
`timescale 1ns/1ps
module far_side_model (
   input  wire logic i_mclk,
   input  wire logic i_rst_n,
   input  wire logic i_fast_osc_on,
   input  wire logic i_slow_osc_on,
   output logic      o_fc_tick,
   output logic      o_fs_tick,
   output logic      o_time_base_src
);
   logic [3:0] div;
   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         div <= 4'h0;
      end else begin
         div <= div + 4'h1;
      end
   end
   // Ticks only while the oscillator runs
   assign o_fc_tick       = i_fast_osc_on;
   assign o_fs_tick       = i_slow_osc_on && (div[1:0] == 2'h3);
   assign o_time_base_src = div[3];
endmodule // far_side_model

//--- verification/standby_mode_controller_test.sv
// Directed bench for the standby mode controller
`timescale 1ns/1ps
module standby_mode_controller_test;
   logic                      i_mclk = 1'b0;
   logic                      i_rst_n = 1'b0;
   logic                      i_ext_reset_n = 1'b1;
   logic                      i_stop_req = 1'b0;
   logic                      i_cpu_halt_set = 1'b0;
   logic                      i_clock_gate_set = 1'b0;
   logic                      i_standby_pin = 1'b1;
   logic                      i_mode_write = 1'b0;
   standby_pkg::op_mode_e     i_mode_next = standby_pkg::fast_single_clock_mode;
   logic [3:0]                i_key_wakeup_n = 4'hF;
   logic [3:0]                i_key_enable = 4'h1;
   logic                      i_fc_tick, i_fs_tick, i_time_base_src;
   standby_pkg::standby_cfg_s i_cfg = 4'h0;
   standby_pkg::irq_s         i_irq = 5'h00;
   standby_pkg::op_mode_e     o_mode;
   logic o_fast_osc_on, o_slow_osc_on, o_cpu_run, o_watchdog_run, o_periph_clk_en;
   logic o_tbt_clk_en, o_divider_clear, o_standby_active, o_cpu_halt_idle;
   logic o_clock_gate_halt, o_timebase_latch_set, o_service_irq, o_resume;
   logic o_pc_hold, o_core_reset, o_warmup_done;
   int   bad_count = 0;
   int   checked = 0;
   int   n;
   logic hit;

   always #5 i_mclk = ~i_mclk;

   standby_mode_controller #(.KEYS(4), .WARM_SHIFT(8)) i_dut (
      .i_mclk, .i_rst_n, .i_ext_reset_n, .i_fc_tick, .i_fs_tick, .i_cfg, .i_irq,
      .i_stop_req, .i_cpu_halt_set, .i_clock_gate_set, .i_mode_write, .i_mode_next,
      .i_standby_pin, .i_key_wakeup_n, .i_key_enable, .i_time_base_src, .o_mode,
      .o_fast_osc_on, .o_slow_osc_on, .o_cpu_run, .o_watchdog_run, .o_periph_clk_en,
      .o_tbt_clk_en, .o_divider_clear, .o_standby_active, .o_cpu_halt_idle,
      .o_clock_gate_halt, .o_timebase_latch_set, .o_service_irq, .o_resume,
      .o_pc_hold, .o_core_reset, .o_warmup_done
   );

   far_side_model i_far (
      .i_mclk, .i_rst_n, .i_fast_osc_on(o_fast_osc_on), .i_slow_osc_on(o_slow_osc_on),
      .o_fc_tick(i_fc_tick), .o_fs_tick(i_fs_tick), .o_time_base_src(i_time_base_src)
   );

   task automatic test_done();
      if (bad_count == 0 && checked > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   task automatic check(input logic [7:0] got, input logic [7:0] exp);
      checked++;
      if (got !== exp) begin
         bad_count++;
         $display("unexpected at %0t: got %0h expected %0h", $time, got, exp);
      end
   endtask

   // Request pulse: 0 standby, 1 cpu halt, 2 clock gate
   task automatic request(input int k);
      @(posedge i_mclk);
      i_stop_req       <= (k == 0);
      i_cpu_halt_set   <= (k == 1);
      i_clock_gate_set <= (k == 2);
      @(posedge i_mclk);
      i_stop_req       <= 1'b0;
      i_cpu_halt_set   <= 1'b0;
      i_clock_gate_set <= 1'b0;
      @(negedge i_mclk);
   endtask

   // Pulse wait: 4 clear, 3 warm done, 2 resume, 1 service
   task automatic wait_pulse(input int sel, input int bound, output int cyc);
      logic [4:0] p;
      for (cyc = 0; cyc < bound; cyc++) begin
         p = {o_divider_clear, o_warmup_done, o_resume, o_service_irq, 1'b0};
         if (p[sel] === 1'b1) return;
         @(negedge i_mclk);
      end
      bad_count++;
      test_done();
   endtask

   initial begin
      repeat (20) @(posedge i_mclk);
      i_rst_n <= 1'b1;
      @(negedge i_mclk);
      check({o_mode, o_fast_osc_on, o_slow_osc_on, o_cpu_run, o_pc_hold, 2'h0}, 8'h28);
      request(0);
      @(negedge i_mclk);
      check({o_standby_active, o_fast_osc_on, o_cpu_run, o_pc_hold}, 8'h9);
      @(posedge i_mclk) i_standby_pin <= 1'b0;
      repeat (3) @(posedge i_mclk);
      i_standby_pin <= 1'b1;
      @(negedge i_mclk);
      wait_pulse(4, 10, n);
      check({o_standby_active, o_fast_osc_on, o_slow_osc_on, o_cpu_run}, 8'h4);
      wait_pulse(3, 1000, n);
      check((n > 765) && (n < 772), 1'b1);
      wait_pulse(2, 3, n);
      check({o_cpu_run, o_pc_hold}, 8'h2);
      @(posedge i_mclk) i_cfg <= 4'hB;
      request(0);
      wait_pulse(4, 3, n);
      check(o_standby_active, 1'b0);
      wait_pulse(3, 20, n);
      check(n < 8, 1'b1);
      wait_pulse(2, 3, n);
      for (int s = 1; s < 3; s++) begin
         @(posedge i_mclk) i_mode_next <= standby_pkg::op_mode_e'(s);
         i_mode_write <= 1'b1;
         @(posedge i_mclk) i_mode_write <= 1'b0;
         i_standby_pin <= (s == 1);
         i_key_wakeup_n <= (s == 1) ? 4'hF : 4'hE;
         request(0);
         wait_pulse(4, 3, n);
         check({o_mode, o_fast_osc_on, o_slow_osc_on}, (s == 1) ? 8'h7 : 8'h9);
         wait_pulse(3, 20, n);
      end
      @(posedge i_mclk) i_standby_pin <= 1'b1;
      i_key_wakeup_n <= 4'hF;
      for (int m = 0; m < 2; m++) begin
         @(posedge i_mclk) i_irq.master_irq_enable <= m[0];
         request(1);
         @(negedge i_mclk);
         check({o_cpu_halt_idle, o_cpu_run, o_watchdog_run, o_periph_clk_en, o_pc_hold},
               8'h13);
         @(posedge i_mclk) i_irq.irq_pending <= 1'b1;
         @(negedge i_mclk);
         wait_pulse((m == 1) ? 1 : 2, 5, n);
         check({o_mode, o_cpu_halt_idle, o_cpu_run}, 8'h9);
         @(posedge i_mclk) i_irq.irq_pending <= 1'b0;
      end
      @(posedge i_mclk) i_irq.watchdog_irq <= 1'b1;
      request(1);
      wait_pulse(1, 3, n);
      @(negedge i_mclk);
      check(o_cpu_halt_idle, 1'b0);
      @(posedge i_mclk) i_irq <= 5'h12;
      for (int t = 0; t < 2; t++) begin
         @(posedge i_mclk) i_irq.time_base_enable <= t[0];
         request(2);
         hit = o_timebase_latch_set;
         @(negedge i_mclk);
         hit = hit | o_timebase_latch_set;
         check(hit, t[0]);
         check({o_clock_gate_halt, o_periph_clk_en, o_tbt_clk_en}, 8'h5);
         wait_pulse((t == 1) ? 1 : 2, 40, n);
         check({o_mode, o_clock_gate_halt}, 8'h4);
      end
      @(posedge i_mclk) i_cfg <= 4'h0;
      request(0);
      @(negedge i_mclk);
      check(o_standby_active, 1'b1);
      @(posedge i_mclk) i_ext_reset_n <= 1'b0;
      repeat (2) @(negedge i_mclk);
      check({o_core_reset, o_standby_active, o_mode}, 8'h8);
      @(posedge i_mclk) i_ext_reset_n <= 1'b1;
      repeat (2) @(negedge i_mclk);
      check({o_core_reset, o_cpu_run, o_fast_osc_on, o_slow_osc_on}, 8'h6);
      test_done();
   end
endmodule // standby_mode_controller_test
